/* File: logic/fpcr_cal_if.sv */
// link between the register bank and its calibration trigger detector
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fpcr_cal_if;
  logic cal_level;
  logic cal_start;
  logic [fpcr_pkg::FPCR_CNT_W-1:0] cal_count;
  modport ctl (output cal_level, input cal_start, input cal_count);
  modport det (input cal_level, output cal_start, output cal_count);
endinterface : fpcr_cal_if
`default_nettype wire

/* File: logic/fpcr_cal_pulse.sv */
// calibration trigger: one start pulse on each low to high of the level
// assumes: level comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpcr_cal_pulse (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // level in, pulse and count out
  fpcr_cal_if.det cal
);
  import fpcr_pkg::*;

  typedef struct packed {
    logic prev;
    logic start;
    logic [FPCR_CNT_W-1:0] count;
  } fpcr_det_t;

  fpcr_det_t st_ff;
  fpcr_det_t nxt_st;

  // ****************************************
  // edge detect and start counter
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = cal.cal_level;
    nxt_st.start = cal.cal_level & ~st_ff.prev;
    if (nxt_st.start) begin
      nxt_st.count = st_ff.count + 4'h1;
    end
  end

  // state register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cal.cal_start = st_ff.start;
  assign cal.cal_count = st_ff.count;

endmodule : fpcr_cal_pulse
`default_nettype wire

/* File: logic/fpcr_pkg.sv */
// constants, field layout and types of the fractional pll config registers
// assumes: included before every other file of the block
package fpcr_pkg;

  // ****************************************
  // bus shape
  // ****************************************
  localparam int FPCR_ADDR_W = 12;
  localparam int FPCR_DATA_W = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [FPCR_ADDR_W-1:0] FPCR_OFS_CONTROL = 12'h100;
  localparam logic [FPCR_ADDR_W-1:0] FPCR_OFS_PATH_MODE = 12'h101;
  localparam logic [FPCR_ADDR_W-1:0] FPCR_OFS_CP_CURRENT = 12'h102;
  localparam logic [FPCR_ADDR_W-1:0] FPCR_OFS_LOOP_FILTER = 12'h103;
  localparam logic [FPCR_ADDR_W-1:0] FPCR_OFS_STATUS = 12'h1F0;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FPCR_CTRL_CAL = 3;
  localparam int FPCR_CTRL_SYNC = 2;
  localparam int FPCR_CTRL_PWRDN = 1;
  localparam int FPCR_CTRL_RESET = 0;
  localparam int FPCR_MODE_DBL = 3;
  localparam int FPCR_MODE_LOOP_LO = 1;
  localparam int FPCR_MODE_SDM_PD = 0;
  localparam int FPCR_LF_RP2_LO = 6;
  localparam int FPCR_LF_RZ_LO = 3;
  localparam int FPCR_LF_CP1_LO = 0;
  localparam int FPCR_STAT_CNT_LO = 4;
  localparam int FPCR_STAT_BAD = 0;

  // ****************************************
  // reset values and widths
  // ****************************************
  localparam logic [3:0] FPCR_CTRL_RST = 4'h0;
  localparam logic [3:0] FPCR_MODE_RST = 4'h1;
  localparam logic [7:0] FPCR_CP_RST = 8'h8D;
  localparam logic [7:0] FPCR_LF_RST = 8'hE0;
  localparam int FPCR_CNT_W = 4;
  localparam int FPCR_UA_W = 10;
  localparam int FPCR_RP2_W = 11;
  localparam int FPCR_RZ_W = 13;
  localparam int FPCR_PF_W = 8;
  localparam logic [FPCR_UA_W-1:0] FPCR_CP_STEP_UA = 10'h004;

  // feedback path selection
  typedef enum logic [1:0] {
    FPCR_LOOP_SINGLE = 2'h0,
    FPCR_LOOP_CASCADE = 2'h1,
    FPCR_LOOP_FIXED_DLY = 2'h2,
    FPCR_LOOP_RESERVED = 2'h3
  } fpcr_loop_mode_t;

endpackage : fpcr_pkg

/* File: logic/fpcr_regs.sv */
// configuration register bank of the fractional pll core
// assumes: single clock, register port with read data one cycle later
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module fpcr_regs (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [fpcr_pkg::FPCR_ADDR_W-1:0] reg_addr_in,
  input wire logic [fpcr_pkg::FPCR_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [fpcr_pkg::FPCR_DATA_W-1:0] reg_rdata_out,
  // pll control
  output logic cal_start_out,
  output logic div_sync_hold_out,
  output logic pll_pwrdn_out,
  output logic pll_reset_out,
  // path and mode
  output logic doubler_sel_out,
  output var fpcr_pkg::fpcr_loop_mode_t loop_mode_out,
  output logic loop_mode_bad_out,
  output logic sdm_pwrdn_out,
  // charge pump
  output logic [7:0] cp_code_out,
  output logic [fpcr_pkg::FPCR_UA_W-1:0] cp_current_ua_out,
  // loop filter
  output logic [1:0] second_pole_resistor_code_out,
  output logic [fpcr_pkg::FPCR_RP2_W-1:0] second_pole_resistor_ohm_out,
  output logic [2:0] zero_resistor_code_out,
  output logic [fpcr_pkg::FPCR_RZ_W-1:0] zero_resistor_ohm_out,
  output logic [2:0] first_pole_capacitor_code_out,
  output logic [fpcr_pkg::FPCR_PF_W-1:0] first_pole_capacitor_pf_out
);
  import fpcr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [3:0] ctrl;
    logic [3:0] mode;
    logic [7:0] cp;
    logic [7:0] lf;
    logic [FPCR_DATA_W-1:0] rdata;
    logic [FPCR_UA_W-1:0] cp_ua;
    logic [FPCR_RP2_W-1:0] rp2_ohm;
    logic [FPCR_RZ_W-1:0] rz_ohm;
    logic [FPCR_PF_W-1:0] cp1_pf;
    logic mode_bad;
  } fpcr_regs_t;

  fpcr_regs_t st_ff;
  fpcr_regs_t nxt_st;

  fpcr_cal_if cal ();

  // ****************************************
  // decode functions
  // ****************************************

  // charge pump current in microamps
  function automatic logic [FPCR_UA_W-1:0] cp_ua_f(input logic [7:0] code);
    cp_ua_f = {2'h0, code} * FPCR_CP_STEP_UA;
  endfunction : cp_ua_f

  // second pole resistor in ohms
  function automatic logic [FPCR_RP2_W-1:0] rp2_ohm_f(input logic [1:0] code);
    case (code)
      2'h0: rp2_ohm_f = 11'h7D0; // 2000
      2'h1: rp2_ohm_f = 11'h29A; // 666
      2'h2: rp2_ohm_f = 11'h190; // 400
      default: rp2_ohm_f = 11'h11D; // 285
    endcase
  endfunction : rp2_ohm_f

  // zero resistor in ohms
  function automatic logic [FPCR_RZ_W-1:0] rz_ohm_f(input logic [2:0] code);
    case (code)
      3'h0: rz_ohm_f = 13'h05DC; // 1500
      3'h1: rz_ohm_f = 13'h0753; // 1875
      3'h2: rz_ohm_f = 13'h08CA; // 2250
      3'h3: rz_ohm_f = 13'h0A5A; // 2650
      3'h4: rz_ohm_f = 13'h0BB8; // 3000
      3'h5: rz_ohm_f = 13'h0D2F; // 3375
      3'h6: rz_ohm_f = 13'h0EA6; // 3750
      default: rz_ohm_f = 13'h101D; // 4125
    endcase
  endfunction : rz_ohm_f

  // first pole capacitor in picofarads
  function automatic logic [FPCR_PF_W-1:0] cp1_pf_f(input logic [2:0] code);
    case (code)
      3'h0: cp1_pf_f = 8'h02;
      3'h1: cp1_pf_f = 8'h08;
      3'h2: cp1_pf_f = 8'h2A;
      3'h3: cp1_pf_f = 8'h30;
      3'h4: cp1_pf_f = 8'h52;
      3'h5: cp1_pf_f = 8'h58;
      3'h6: cp1_pf_f = 8'h7A;
      default: cp1_pf_f = 8'h80;
    endcase
  endfunction : cp1_pf_f

  // register hit test
  function automatic logic hit_f(input logic [FPCR_ADDR_W-1:0] a,
                                 input logic [FPCR_ADDR_W-1:0] ofs);
    hit_f = (a == ofs);
  endfunction : hit_f

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    // writes: only the implemented low bits are stored
    if (reg_wr_in) begin
      if (hit_f(reg_addr_in, FPCR_OFS_CONTROL)) begin
        nxt_st.ctrl = reg_wdata_in[3:0];
      end
      if (hit_f(reg_addr_in, FPCR_OFS_PATH_MODE)) begin
        nxt_st.mode = reg_wdata_in[3:0];
      end
      if (hit_f(reg_addr_in, FPCR_OFS_CP_CURRENT)) begin
        nxt_st.cp = reg_wdata_in;
      end
      if (hit_f(reg_addr_in, FPCR_OFS_LOOP_FILTER)) begin
        nxt_st.lf = reg_wdata_in;
      end
    end
    // reads: data stands one cycle only, zero otherwise
    nxt_st.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        FPCR_OFS_CONTROL: nxt_st.rdata = {4'h0, st_ff.ctrl};
        FPCR_OFS_PATH_MODE: nxt_st.rdata = {4'h0, st_ff.mode};
        FPCR_OFS_CP_CURRENT: nxt_st.rdata = st_ff.cp;
        FPCR_OFS_LOOP_FILTER: nxt_st.rdata = st_ff.lf;
        FPCR_OFS_STATUS: nxt_st.rdata = {cal.cal_count, 3'h0, st_ff.mode_bad};
        default: nxt_st.rdata = '0;
      endcase
    end
    // decoded analog settings follow the new field values
    nxt_st.cp_ua = cp_ua_f(nxt_st.cp);
    nxt_st.rp2_ohm = rp2_ohm_f(nxt_st.lf[FPCR_LF_RP2_LO +: 2]);
    nxt_st.rz_ohm = rz_ohm_f(nxt_st.lf[FPCR_LF_RZ_LO +: 3]);
    nxt_st.cp1_pf = cp1_pf_f(nxt_st.lf[FPCR_LF_CP1_LO +: 3]);
    // reserved loop code is stored but flagged
    nxt_st.mode_bad = (nxt_st.mode[FPCR_MODE_LOOP_LO +: 2] == 2'h3);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
      st_ff.ctrl <= FPCR_CTRL_RST;
      st_ff.mode <= FPCR_MODE_RST;
      st_ff.cp <= FPCR_CP_RST;
      st_ff.lf <= FPCR_LF_RST;
      st_ff.cp_ua <= 10'h234; // 4 x 0x8D
      st_ff.rp2_ohm <= 11'h11D;
      st_ff.rz_ohm <= 13'h0BB8;
      st_ff.cp1_pf <= 8'h02;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // calibration trigger
  // ****************************************
  assign cal.cal_level = st_ff.ctrl[FPCR_CTRL_CAL];

  fpcr_cal_pulse u_cal_pulse (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .cal(cal)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_out = st_ff.rdata;
  assign cal_start_out = cal.cal_start;
  assign div_sync_hold_out = st_ff.ctrl[FPCR_CTRL_SYNC];
  assign pll_pwrdn_out = st_ff.ctrl[FPCR_CTRL_PWRDN];
  assign pll_reset_out = st_ff.ctrl[FPCR_CTRL_RESET];
  assign doubler_sel_out = st_ff.mode[FPCR_MODE_DBL];
  assign loop_mode_out = fpcr_loop_mode_t'(st_ff.mode[FPCR_MODE_LOOP_LO +: 2]);
  assign loop_mode_bad_out = st_ff.mode_bad;
  assign sdm_pwrdn_out = st_ff.mode[FPCR_MODE_SDM_PD];
  assign cp_code_out = st_ff.cp;
  assign cp_current_ua_out = st_ff.cp_ua;
  assign second_pole_resistor_code_out = st_ff.lf[FPCR_LF_RP2_LO +: 2];
  assign second_pole_resistor_ohm_out = st_ff.rp2_ohm;
  assign zero_resistor_code_out = st_ff.lf[FPCR_LF_RZ_LO +: 3];
  assign zero_resistor_ohm_out = st_ff.rz_ohm;
  assign first_pole_capacitor_code_out = st_ff.lf[FPCR_LF_CP1_LO +: 3];
  assign first_pole_capacitor_pf_out = st_ff.cp1_pf;

  // ****************************************
  // checks
  // ****************************************
  default clocking dflt_cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // helper: fields not yet written since reset
  logic mode_seen_ff;
  logic cp_seen_ff;
  logic lf_seen_ff;
  logic ctrl_seen_ff;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_seen_ff <= 1'b0;
      cp_seen_ff <= 1'b0;
      lf_seen_ff <= 1'b0;
      ctrl_seen_ff <= 1'b0;
    end else begin
      mode_seen_ff <= mode_seen_ff | (reg_wr_in & hit_f(reg_addr_in, FPCR_OFS_PATH_MODE));
      cp_seen_ff <= cp_seen_ff | (reg_wr_in & hit_f(reg_addr_in, FPCR_OFS_CP_CURRENT));
      lf_seen_ff <= lf_seen_ff | (reg_wr_in & hit_f(reg_addr_in, FPCR_OFS_LOOP_FILTER));
      ctrl_seen_ff <= ctrl_seen_ff | (reg_wr_in & hit_f(reg_addr_in, FPCR_OFS_CONTROL));
    end
  end

  sequence s_ctrl_wr;
    reg_wr_in && reg_addr_in == FPCR_OFS_CONTROL;
  endsequence
  sequence s_cal_rise;
    s_ctrl_wr ##0 (reg_wdata_in[FPCR_CTRL_CAL] && !st_ff.ctrl[FPCR_CTRL_CAL]);
  endsequence
  sequence s_mode_wr;
    reg_wr_in && reg_addr_in == FPCR_OFS_PATH_MODE;
  endsequence
  sequence s_lf_wr;
    reg_wr_in && reg_addr_in == FPCR_OFS_LOOP_FILTER;
  endsequence
  sequence s_cp_wr;
    reg_wr_in && reg_addr_in == FPCR_OFS_CP_CURRENT;
  endsequence
  // reads of no mapped register
  sequence s_unmapped_rd;
    reg_rd_in && reg_addr_in != FPCR_OFS_CONTROL && reg_addr_in != FPCR_OFS_PATH_MODE
      && reg_addr_in != FPCR_OFS_CP_CURRENT && reg_addr_in != FPCR_OFS_LOOP_FILTER
      && reg_addr_in != FPCR_OFS_STATUS;
  endsequence

  a_cal_edge_pulse:
    assert property (s_cal_rise |=> !cal_start_out ##1 cal_start_out)
    else $error("calibration start missing after bit rise");
  a_cal_only_rise:
    assert property (cal_start_out |-> $past(cal.cal_level) && !$past(cal.cal_level, 2))
    else $error("calibration start without a rise");
  a_sync_hold_follow:
    assert property (s_ctrl_wr |=> div_sync_hold_out == $past(reg_wdata_in[FPCR_CTRL_SYNC]))
    else $error("sync hold does not follow control write");
  a_doubler_path_sel:
    assert property (s_mode_wr |=> doubler_sel_out == $past(reg_wdata_in[FPCR_MODE_DBL]))
    else $error("doubler select does not follow write");
  a_loop_mode_map:
    assert property (s_mode_wr |=> loop_mode_out == $past(reg_wdata_in[2:1])
                     && loop_mode_bad_out == (loop_mode_out == FPCR_LOOP_RESERVED))
    else $error("loop mode or its flag wrong");
  a_sdm_pd_reset:
    assert property (!mode_seen_ff |-> sdm_pwrdn_out)
    else $error("modulator not powered down after reset");
  a_cp_scale_reset:
    assert property ((!cp_seen_ff |-> cp_code_out == 8'h8D)
                     and (cp_current_ua_out == {cp_code_out, 2'h0}))
    else $error("charge pump current wrong");
  a_second_pole_code:
    assert property (s_lf_wr ##0 reg_wdata_in[7:6] == 2'h3 |=> second_pole_resistor_ohm_out == 11'h11D)
    else $error("second pole resistor code 3 not 285 ohm");
  a_zero_res_code:
    assert property (s_lf_wr ##0 reg_wdata_in[5:3] == 3'h0 |=> zero_resistor_ohm_out == 13'h05DC)
    else $error("zero resistor code 0 not 1500 ohm");
  a_first_pole_code:
    assert property (s_lf_wr ##0 reg_wdata_in[2:0] == 3'h7 |=> first_pole_capacitor_pf_out == 8'h80)
    else $error("first pole capacitor code 7 not 128 pF");
  a_pll_hold_bits:
    assert property (s_ctrl_wr |=> pll_pwrdn_out == $past(reg_wdata_in[FPCR_CTRL_PWRDN])
                     && pll_reset_out == $past(reg_wdata_in[FPCR_CTRL_RESET]))
    else $error("power-down or reset bit not applied");
  a_reserved_read_zero:
    assert property (reg_rd_in && (reg_addr_in == FPCR_OFS_CONTROL
                     || reg_addr_in == FPCR_OFS_PATH_MODE) |=> reg_rdata_out[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  // field writes, read answers and unmapped places
  a_rdata_one_cycle:
    assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside the answer cycle");
  a_unmapped_read_zero:
    assert property (s_unmapped_rd |=> reg_rdata_out == 8'h00)
    else $error("unmapped address read nonzero");
  // status count steps once per start
  a_cal_count_step:
    assert property (cal_start_out |-> cal.cal_count == $past(cal.cal_count) + 4'h1)
    else $error("calibration count not stepped with the start");
  a_sdm_pd_follow:
    assert property (s_mode_wr |=> sdm_pwrdn_out == $past(reg_wdata_in[FPCR_MODE_SDM_PD]))
    else $error("modulator power-down does not follow write");
  a_cp_field_write:
    assert property (s_cp_wr |=> cp_code_out == $past(reg_wdata_in))
    else $error("charge pump field does not follow write");
  a_lf_field_write:
    assert property (s_lf_wr |=> {second_pole_resistor_code_out, zero_resistor_code_out,
                     first_pole_capacitor_code_out} == $past(reg_wdata_in))
    else $error("loop filter codes do not follow write");
  // settings sit at reset values until first written
  a_lf_reset_value:
    assert property (!lf_seen_ff |-> second_pole_resistor_ohm_out == 11'h11D
                     && zero_resistor_ohm_out == 13'h0BB8
                     && first_pole_capacitor_pf_out == 8'h02)
    else $error("loop filter not at reset setting");
  a_ctrl_reset_value:
    assert property (!ctrl_seen_ff |-> !pll_pwrdn_out && !pll_reset_out && !div_sync_hold_out)
    else $error("control bits not cleared after reset");
  // settings stand untouched between writes
  a_outputs_stand:
    assert property (!reg_wr_in |=> $stable({div_sync_hold_out, pll_pwrdn_out, pll_reset_out,
                     doubler_sel_out, loop_mode_out, sdm_pwrdn_out, cp_code_out,
                     second_pole_resistor_code_out, zero_resistor_code_out,
                     first_pole_capacitor_code_out}))
    else $error("settings moved without a write");

endmodule : fpcr_regs
`default_nettype wire

/* File: test/tb_frac_pll_config_regs.sv */
// self-checking bench of the fractional pll configuration register bank
// assumes: logic/ files compiled first, design assertions live in the design
`timescale 1ns/1ps
`default_nettype none
module tb_frac_pll_config_regs import fpcr_pkg::*;;
  // ****************************************
  // signals
  // ****************************************
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, cp_code;
  logic cal, hold, pwrdn, prst, dbl, bad, sdm;
  fpcr_loop_mode_t lmode;
  logic [9:0] ua;
  logic [1:0] rp_c;
  logic [10:0] rp_o;
  logic [2:0] rz_c, c1_c;
  logic [12:0] rz_o;
  logic [7:0] c1_p;
  logic [7:0] sh [4];
  logic [15:0] lfsr = 16'hFDB6;
  int err_count = 0;
  int samples_checked = 0;

  // 5 ns clock
  always #2.5 core_clk = ~core_clk;

  fpcr_regs i_dut (
    .core_clk_in(core_clk), .resetn_in(resetn), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .cal_start_out(cal), .div_sync_hold_out(hold), .pll_pwrdn_out(pwrdn),
    .pll_reset_out(prst), .doubler_sel_out(dbl), .loop_mode_out(lmode),
    .loop_mode_bad_out(bad), .sdm_pwrdn_out(sdm), .cp_code_out(cp_code),
    .cp_current_ua_out(ua), .second_pole_resistor_code_out(rp_c),
    .second_pole_resistor_ohm_out(rp_o), .zero_resistor_code_out(rz_c),
    .zero_resistor_ohm_out(rz_o), .first_pole_capacitor_code_out(c1_c),
    .first_pole_capacitor_pf_out(c1_p)
  );

  // ****************************************
  // expectation helpers
  // ****************************************
  // next pseudo-random word
  function automatic logic [15:0] nxt_rand(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction : nxt_rand

  // ohms of the second pole resistor code
  function automatic logic [15:0] rp_ohm(input logic [1:0] c);
    logic [15:0] t [4] = '{16'h07D0, 16'h029A, 16'h0190, 16'h011D};
    return t[c];
  endfunction : rp_ohm

  // ohms of the zero resistor code
  function automatic logic [15:0] rz_ohm(input logic [2:0] c);
    logic [15:0] t [8] = '{16'h05DC, 16'h0753, 16'h08CA, 16'h0A5A,
                           16'h0BB8, 16'h0D2F, 16'h0EA6, 16'h101D};
    return t[c];
  endfunction : rz_ohm

  // picofarads of the first pole capacitor code
  function automatic logic [15:0] c1_pf(input logic [2:0] c);
    logic [15:0] t [8] = '{16'h0002, 16'h0008, 16'h002A, 16'h0030,
                           16'h0052, 16'h0058, 16'h007A, 16'h0080};
    return t[c];
  endfunction : c1_pf

  // ****************************************
  // bus and compare tasks
  // ****************************************
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write, returns in the cycle after
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // two writes to one address with no gap between them
  task automatic wr_pair(input logic [11:0] a, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d0;
    @(posedge core_clk);
    wdata <= d1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_pair

  // one-cycle read, data taken in the cycle after, zero the cycle after that
  task automatic rd_check(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge core_clk);
    #1;
    check(rdata, 8'h00);
  endtask : rd_check

  // count start pulses over a few cycles
  task automatic count_pulses(input int n, output int p);
    p = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (cal !== 1'b0) p++; // unknown counts as a pulse
    end
  endtask : count_pulses

  // outputs and read-back against the shadow copy
  task automatic check_all();
    check(hold, sh[0][2]);
    check(pwrdn, sh[0][1]);
    check(prst, sh[0][0]);
    check(dbl, sh[1][3]);
    check(lmode, sh[1][2:1]);
    check(bad, sh[1][2:1] == 2'h3);
    check(sdm, sh[1][0]);
    check(cp_code, sh[2]);
    check(ua, {sh[2], 2'h0});
    check(rp_c, sh[3][7:6]);
    check(rp_o, rp_ohm(sh[3][7:6]));
    check(rz_c, sh[3][5:3]);
    check(rz_o, rz_ohm(sh[3][5:3]));
    check(c1_c, sh[3][2:0]);
    check(c1_p, c1_pf(sh[3][2:0]));
    for (int i = 0; i < 2; i++) rd_check(FPCR_OFS_CONTROL + 12'(i), sh[i] & 8'h0F);
    rd_check(FPCR_OFS_CP_CURRENT, sh[2]);
    rd_check(FPCR_OFS_LOOP_FILTER, sh[3]);
  endtask : check_all

  // reset held five cycles, shadow back to reset values
  task automatic apply_reset();
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    sh = '{8'h00, 8'h01, 8'h8D, 8'hE0};
    #1;
    check(cal, 1'b0);
    check_all();
  endtask : apply_reset

  // run verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // ****************************************
  // scenarios
  // ****************************************
  // guard against a hang
  initial begin
    #250000;
    err_count++;
    conclude();
  end

  // main sequence
  initial begin : main
    int p;
    logic [1:0] idx;
    apply_reset();
    // every loop mode code with the doubler both ways
    for (int m = 0; m < 8; m++) begin
      sh[1] = {4'hA, m[0], m[2:1], 1'b0};
      wr_reg(FPCR_OFS_PATH_MODE, sh[1]);
      check_all();
    end
    // random writes, upper bits of control and mode must be dropped
    repeat (40) begin
      lfsr = nxt_rand(lfsr);
      idx = lfsr[1:0];
      sh[idx] = lfsr[15:8];
      wr_reg(FPCR_OFS_CONTROL + 12'(idx), lfsr[15:8]);
      check_all();
    end
    // unmapped and read-only places take nothing
    wr_reg(12'h104, 8'hFF);
    wr_reg(FPCR_OFS_STATUS, 8'hFF);
    rd_check(12'h104, 8'h00);
    check_all();
    // rise of the calibration bit: one pulse exactly two cycles on
    wr_reg(FPCR_OFS_CONTROL, 8'h00);
    wr_reg(FPCR_OFS_CONTROL, 8'h08);
    check(cal, 1'b0);
    @(posedge core_clk);
    #1;
    check(cal, 1'b1);
    @(posedge core_clk);
    #1;
    check(cal, 1'b0);
    // writing one again, then clearing, starts nothing
    wr_reg(FPCR_OFS_CONTROL, 8'h0C);
    count_pulses(4, p);
    check(p, 0);
    wr_reg(FPCR_OFS_CONTROL, 8'h04);
    count_pulses(4, p);
    check(p, 0);
    // set after a clear: a fresh pulse
    wr_reg(FPCR_OFS_CONTROL, 8'h0B);
    count_pulses(3, p);
    check(p, 1);
    // clear then set with no gap between the writes: one pulse again
    wr_pair(FPCR_OFS_CONTROL, 8'h03, 8'h0B);
    count_pulses(3, p);
    check(p, 1);
    sh[0] = 8'h0B;
    check_all();
    // reset in mid-run restores every field
    apply_reset();
    // status: one start counted since reset, then the reserved loop flag
    wr_reg(FPCR_OFS_CONTROL, 8'h08);
    count_pulses(3, p);
    check(p, 1);
    rd_check(FPCR_OFS_STATUS, 8'h10);
    wr_reg(FPCR_OFS_PATH_MODE, 8'h06);
    rd_check(FPCR_OFS_STATUS, 8'h11);
    conclude();
  end : main
endmodule : tb_frac_pll_config_regs
`default_nettype wire
